// *** design/csrf_defs.vh ***
// Constants shared by the CPU special register file
`ifndef CSRF_DEFS_VH
`define CSRF_DEFS_VH
// Register numbers
`define CSRF_REG_PC 4'h0
`define CSRF_REG_SP 4'h1
`define CSRF_REG_SW 4'h2
`define CSRF_REG_CG 4'h3
// Operation sizes
`define CSRF_SZ_BYTE 2'h0
`define CSRF_SZ_WORD 2'h1
`define CSRF_SZ_ADDR 2'h2
// Source mode field encodings
`define CSRF_AS_REG 2'h0
`define CSRF_AS_IDX 2'h1
`define CSRF_AS_IND 2'h2
`define CSRF_AS_INC 2'h3
// Status word bit positions
`define CSRF_SW_C 0
`define CSRF_SW_Z 1
`define CSRF_SW_N 2
`define CSRF_SW_GIE 3
`define CSRF_SW_CORE_HALT 4
`define CSRF_SW_XSTOP 5
`define CSRF_SW_CGLO 6
`define CSRF_SW_CGHI 7
`define CSRF_SW_V 8
// Constant generator values
`define CSRF_K_ZERO 20'h00000
`define CSRF_K_ONE 20'h00001
`define CSRF_K_TWO 20'h00002
`define CSRF_K_FOUR 20'h00004
`define CSRF_K_EIGHT 20'h00008
`define CSRF_K_BONES 20'h000FF
`define CSRF_K_WONES 20'h0FFFF
`define CSRF_K_AONES 20'hFFFFF
// Stack adjustment for returns
`define CSRF_RET_LONG 20'h00004
`define CSRF_RET_SHORT 20'h00002
// Reset values
`define CSRF_RST_SP 20'h00000
`define CSRF_RST_SW 16'h0000
`define CSRF_RST_GP 20'h00000
`endif

// *** design/csrf_flags.v ***
// Arithmetic flag generator for the status word
`include "csrf_defs.vh"
module csrf_flags (
	input wire [19:0] i_src,
	input wire [19:0] i_dst,
	input wire [19:0] i_res,
	input wire i_carry,
	input wire [1:0] i_size,
	input wire i_is_add,
	input wire i_is_sub,
	output reg o_neg,
	output reg o_zero,
	output wire o_carry,
	output reg o_ovf
);
	reg s_src;
	reg s_dst;
	reg s_res;

	// Sign bits and zero test at the operation size
	always @* begin
		case (i_size)
			`CSRF_SZ_BYTE: begin
				s_src = i_src[7];
				s_dst = i_dst[7];
				s_res = i_res[7];
				o_zero = (i_res[7:0] == 8'h00);
			end
			`CSRF_SZ_WORD: begin
				s_src = i_src[15];
				s_dst = i_dst[15];
				s_res = i_res[15];
				o_zero = (i_res[15:0] == 16'h0000);
			end
			default: begin
				s_src = i_src[19];
				s_dst = i_dst[19];
				s_res = i_res[19];
				o_zero = (i_res == 20'h00000);
			end
		endcase
		o_neg = s_res;
		if (i_is_add) begin
			o_ovf = (s_src == s_dst) && (s_res != s_dst);
		end else if (i_is_sub) begin
			o_ovf = (s_src != s_dst) && (s_res != s_dst);
		end else begin
			o_ovf = 1'b0;
		end
	end

	assign o_carry = i_carry;
endmodule

// *** design/csrf_top.v ***
// CPU special and working register file with status word
`include "csrf_defs.vh"
module csrf_top #(
	parameter NUM_GP = 12
) (
	input wire i_mclk,
	input wire i_srst,
	input wire i_ce,
	input wire [3:0] i_rd_sel,
	input wire [1:0] i_rd_mode,
	input wire [1:0] i_rd_size,
	output reg [19:0] o_rd_data,
	output reg o_rd_is_const,
	input wire i_wr_en,
	input wire [3:0] i_wr_sel,
	input wire [1:0] i_wr_size,
	input wire i_wr_sxt,
	input wire [19:0] i_wr_data,
	input wire i_sp_push,
	input wire [19:0] i_sp_push_amt,
	input wire i_sp_pop,
	input wire [19:0] i_sp_pop_amt,
	input wire i_ret_long,
	input wire i_ret_short,
	input wire i_flag_en,
	input wire [3:0] i_flag_mask,
	input wire [19:0] i_op_src,
	input wire [19:0] i_op_dst,
	input wire [19:0] i_op_res,
	input wire i_op_carry,
	input wire i_op_is_add,
	input wire i_op_is_sub,
	input wire i_xtal_in_use,
	input wire i_mirq_req,
	output reg [19:0] o_stack_pointer,
	output reg [15:0] o_status_word,
	output wire o_clock_gen_ctl_hi,
	output wire o_clock_gen_ctl_lo,
	output wire o_low_freq_xtal_off,
	output wire o_core_halt,
	output wire o_mirq_accept
);
	// ************************************
	// Storage
	// ************************************
	reg [19:0] sp_q;
	reg [19:0] sp_d;
	reg [15:0] sw_q;
	reg [15:0] sw_d;
	reg [19:0] gp_q [0:NUM_GP-1];
	wire [19:0] wr_val;
	wire f_neg;
	wire f_zero;
	wire f_carry;
	wire f_ovf;
	integer k;

	// Shape write data by size
	function [19:0] size_fill;
		input [19:0] val;
		input [1:0] size;
		input sign_extend_byte;
		begin
			if (sign_extend_byte) begin
				size_fill = {{12{val[7]}}, val[7:0]};
			end else begin
				case (size)
					`CSRF_SZ_BYTE: size_fill = {12'h000, val[7:0]};
					`CSRF_SZ_WORD: size_fill = {4'h0, val[15:0]};
					default: size_fill = val;
				endcase
			end
		end
	endfunction

	assign wr_val = size_fill(i_wr_data, i_wr_size, i_wr_sxt);

	// ************************************
	// Flag generation
	// ************************************
	csrf_flags u_flags (
		.i_src(i_op_src),
		.i_dst(i_op_dst),
		.i_res(i_op_res),
		.i_carry(i_op_carry),
		.i_size(i_rd_size),
		.i_is_add(i_op_is_add),
		.i_is_sub(i_op_is_sub),
		.o_neg(f_neg),
		.o_zero(f_zero),
		.o_carry(f_carry),
		.o_ovf(f_ovf)
	);

	// ************************************
	// Stack pointer next value
	// ************************************
	always @* begin
		sp_d = sp_q;
		if (i_wr_en && i_wr_sel == `CSRF_REG_SP) begin
			sp_d = wr_val;
		end else if (i_sp_push) begin
			sp_d = sp_q - i_sp_push_amt;
		end else if (i_ret_long) begin
			sp_d = sp_q + `CSRF_RET_LONG;
		end else if (i_ret_short) begin
			sp_d = sp_q + `CSRF_RET_SHORT;
		end else if (i_sp_pop) begin
			sp_d = sp_q + i_sp_pop_amt;
		end
		sp_d[0] = 1'b0;
	end

	// ************************************
	// Status word next value
	// ************************************
	always @* begin
		sw_d = sw_q;
		if (i_flag_en) begin
			if (i_flag_mask[0]) begin
				sw_d[`CSRF_SW_C] = f_carry;
			end
			if (i_flag_mask[1]) begin
				sw_d[`CSRF_SW_Z] = f_zero;
			end
			if (i_flag_mask[2]) begin
				sw_d[`CSRF_SW_N] = f_neg;
			end
			if (i_flag_mask[3]) begin
				sw_d[`CSRF_SW_V] = f_ovf;
			end
		end
		// explicit write wins, low 16 bits only
		if (i_wr_en && i_wr_sel == `CSRF_REG_SW) begin
			sw_d = wr_val[15:0];
		end
	end

	// ************************************
	// Register update
	// ************************************
	always @(posedge i_mclk) begin
		if (i_srst) begin
			sp_q <= `CSRF_RST_SP;
			sw_q <= `CSRF_RST_SW;
			for (k = 0; k < NUM_GP; k = k + 1) begin
				gp_q[k] <= `CSRF_RST_GP;
			end
		end else if (i_ce) begin
			sp_q <= sp_d;
			sw_q <= sw_d;
			for (k = 0; k < NUM_GP; k = k + 1) begin
				if (i_wr_en && i_wr_sel == k[3:0] + 4'h4) begin
					gp_q[k] <= wr_val;
				end
			end
		end
	end

	// ************************************
	// Source read and constant generator
	// ************************************
	always @(posedge i_mclk) begin
		if (i_srst) begin
			o_rd_data <= 20'h00000;
			o_rd_is_const <= 1'b0;
		end else if (i_ce) begin
			o_rd_is_const <= 1'b0;
			case (i_rd_sel)
				`CSRF_REG_PC: begin
					o_rd_data <= 20'h00000;
				end
				`CSRF_REG_SP: begin
					o_rd_data <= sp_q;
				end
				`CSRF_REG_SW: begin
					case (i_rd_mode)
						`CSRF_AS_REG: o_rd_data <= {4'h0, sw_q};
						`CSRF_AS_IDX: o_rd_data <= `CSRF_K_ZERO;
						`CSRF_AS_IND: o_rd_data <= `CSRF_K_FOUR;
						default: o_rd_data <= `CSRF_K_EIGHT;
					endcase
					o_rd_is_const <= (i_rd_mode != `CSRF_AS_REG);
				end
				`CSRF_REG_CG: begin
					case (i_rd_mode)
						`CSRF_AS_REG: o_rd_data <= `CSRF_K_ZERO;
						`CSRF_AS_IDX: o_rd_data <= `CSRF_K_ONE;
						`CSRF_AS_IND: o_rd_data <= `CSRF_K_TWO;
						default: begin
							case (i_rd_size)
								`CSRF_SZ_BYTE: o_rd_data <= `CSRF_K_BONES;
								`CSRF_SZ_WORD: o_rd_data <= `CSRF_K_WONES;
								default: o_rd_data <= `CSRF_K_AONES;
							endcase
						end
					endcase
					o_rd_is_const <= 1'b1;
				end
				default: begin
					o_rd_data <= gp_q[i_rd_sel - 4'h4];
				end
			endcase
		end
	end

	// ************************************
	// Exported state and controls
	// ************************************
	always @(posedge i_mclk) begin
		if (i_srst) begin
			o_stack_pointer <= `CSRF_RST_SP;
			o_status_word <= `CSRF_RST_SW;
		end else if (i_ce) begin
			o_stack_pointer <= sp_d;
			o_status_word <= sw_d;
		end
	end

	assign o_clock_gen_ctl_hi = sw_q[`CSRF_SW_CGHI];
	assign o_clock_gen_ctl_lo = sw_q[`CSRF_SW_CGLO];
	assign o_low_freq_xtal_off = sw_q[`CSRF_SW_XSTOP] & ~i_xtal_in_use;
	assign o_core_halt = sw_q[`CSRF_SW_CORE_HALT];
	assign o_mirq_accept = i_mirq_req & sw_q[`CSRF_SW_GIE];
endmodule

// *** dv/csrf_chk.sv ***
// Port assertions for the special register file
module csrf_chk (
	input wire i_mclk,
	input wire i_srst,
	input wire i_ce,
	input wire i_wr_en,
	input wire [3:0] i_rd_sel,
	input wire [1:0] i_rd_mode,
	input wire [19:0] o_rd_data,
	input wire o_rd_is_const,
	input wire i_sp_push,
	input wire [19:0] i_sp_push_amt,
	input wire i_ret_long,
	input wire i_xtal_in_use,
	input wire i_mirq_req,
	input wire [19:0] o_stack_pointer,
	input wire [15:0] o_status_word,
	input wire o_clock_gen_ctl_hi,
	input wire o_clock_gen_ctl_lo,
	input wire o_low_freq_xtal_off,
	input wire o_core_halt,
	input wire o_mirq_accept
);
	default clocking @(posedge i_mclk); endclocking
	default disable iff (i_srst);
	// Push accepted with no competing write
	sequence s_push;
		i_ce && i_sp_push && !i_wr_en;
	endsequence
	property p_sp_even; o_stack_pointer[0] == 1'h0; endproperty
	a_sp_even: assert property (p_sp_even) else $error("stack pointer odd");
	property p_push; s_push |=> o_stack_pointer == (($past(o_stack_pointer) - $past(i_sp_push_amt)) & 20'hFFFFE); endproperty
	a_push: assert property (p_push) else $error("push adjust wrong");
	property p_ret; i_ce && i_ret_long && !i_sp_push && !i_wr_en |=> o_stack_pointer == $past(o_stack_pointer) + 20'h00004; endproperty
	a_ret: assert property (p_ret) else $error("long return adjust wrong");
	property p_cg; {o_clock_gen_ctl_hi, o_clock_gen_ctl_lo} == o_status_word[7:6]; endproperty
	a_cg: assert property (p_cg) else $error("clock controls wrong");
	property p_xoff; o_low_freq_xtal_off == (o_status_word[5] && !i_xtal_in_use); endproperty
	a_xoff: assert property (p_xoff) else $error("crystal stop wrong");
	property p_halt; o_core_halt == o_status_word[4]; endproperty
	a_halt: assert property (p_halt) else $error("halt wrong");
	property p_irq; o_mirq_accept == (i_mirq_req && o_status_word[3]); endproperty
	a_irq: assert property (p_irq) else $error("irq accept wrong");
	property p_k3; i_ce && i_rd_sel == 4'h3 && i_rd_mode == 2'h2 |=> o_rd_data == 20'h00002 && o_rd_is_const; endproperty
	a_k3: assert property (p_k3) else $error("constant two wrong");
endmodule
bind csrf_top csrf_chk i_chk (.i_mclk, .i_srst, .i_ce, .i_wr_en, .i_rd_sel, .i_rd_mode, .o_rd_data, .o_rd_is_const,
	.i_sp_push, .i_sp_push_amt, .i_ret_long, .i_xtal_in_use, .i_mirq_req, .o_stack_pointer, .o_status_word,
	.o_clock_gen_ctl_hi, .o_clock_gen_ctl_lo, .o_low_freq_xtal_off, .o_core_halt, .o_mirq_accept);

// *** dv/csrf_exec_model.sv ***
// Execute datapath model producing word results and carry
module csrf_exec_model (
	input wire [19:0] i_src,
	input wire [19:0] i_dst,
	input wire i_sub,
	output logic [19:0] o_res,
	output logic o_carry
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [16:0] sum_d;
	// Subtract carries out when no borrow occurs
	always_comb begin
		sum_d = {1'h0, i_dst[15:0]} + (i_sub ? {1'h0, ~i_src[15:0]} + 17'h00001 : {1'h0, i_src[15:0]});
		o_res = {4'h0, sum_d[15:0]};
		o_carry = sum_d[16];
	end
endmodule

// *** dv/csrf_top_tb.sv ***
// Self-checking bench for the special register file
module csrf_top_tb;
	timeunit 1ns;
	timeprecision 1ns;
	logic i_mclk = 1'h0, i_srst = 1'h1, i_ce = 1'h1, i_wr_en = 1'h0, i_wr_sxt = 1'h0, i_sp_push = 1'h0, i_sp_pop = 1'h0;
	logic i_ret_long = 1'h0, i_ret_short = 1'h0, i_flag_en = 1'h0, i_op_is_add = 1'h0, i_op_is_sub = 1'h0;
	logic i_xtal_in_use = 1'h0, i_mirq_req = 1'h1, i_op_carry, o_rd_is_const, o_clock_gen_ctl_hi, o_clock_gen_ctl_lo;
	logic o_low_freq_xtal_off, o_core_halt, o_mirq_accept;
	logic [3:0] i_rd_sel = 4'h0, i_wr_sel = 4'h0, i_flag_mask = 4'hF;
	logic [1:0] i_rd_mode = 2'h0, i_rd_size = 2'h1, i_wr_size = 2'h0;
	logic [19:0] i_wr_data = 20'h00000, amt = 20'h00000, i_op_src = 20'h00000, i_op_dst = 20'h00000;
	logic [19:0] i_op_res, o_rd_data, o_stack_pointer;
	logic [15:0] o_status_word;
	int err_count = 0;
	int n_tests = 0;
	`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin err_count++; $display("[ERR] %0t got %h exp %h", $time, a, b); end end
	csrf_top i_dut (.i_mclk, .i_srst, .i_ce, .i_rd_sel, .i_rd_mode, .i_rd_size, .o_rd_data, .o_rd_is_const, .i_wr_en,
		.i_wr_sel, .i_wr_size, .i_wr_sxt, .i_wr_data, .i_sp_push, .i_sp_push_amt(amt), .i_sp_pop, .i_sp_pop_amt(amt),
		.i_ret_long, .i_ret_short, .i_flag_en, .i_flag_mask, .i_op_src, .i_op_dst, .i_op_res, .i_op_carry,
		.i_op_is_add, .i_op_is_sub, .i_xtal_in_use, .i_mirq_req, .o_stack_pointer, .o_status_word,
		.o_clock_gen_ctl_hi, .o_clock_gen_ctl_lo, .o_low_freq_xtal_off, .o_core_halt, .o_mirq_accept);
	csrf_exec_model i_exec (.i_src(i_op_src), .i_dst(i_op_dst), .i_sub(i_op_is_sub), .o_res(i_op_res),
		.o_carry(i_op_carry));
	// Clock at 100 ns
	initial begin
		forever #50 i_mclk = ~i_mclk;
	end
	task automatic finish_test;
		if (err_count == 0 && n_tests > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	// One-cycle register write
	task automatic wr(input logic [3:0] s, input logic [1:0] z, input logic x, input logic [19:0] d);
		@(negedge i_mclk);
		i_wr_en = 1'h1;
		i_wr_sel = s;
		i_wr_size = z;
		i_wr_sxt = x;
		i_wr_data = d;
		@(negedge i_mclk);
		i_wr_en = 1'h0;
	endtask
	// Source read, data checked next cycle
	task automatic rd(input logic [3:0] s, input logic [1:0] m, input logic [1:0] z, input logic [19:0] e);
		@(negedge i_mclk);
		i_rd_sel = s;
		i_rd_mode = m;
		i_rd_size = z;
		@(negedge i_mclk);
		`CHK(o_rd_data, e)
	endtask
	// Stack pointer adjust request
	task automatic spo(input logic p, input logic q, input logic l, input logic r, input logic [19:0] a,
		input logic [19:0] e);
		@(negedge i_mclk);
		{i_sp_push, i_sp_pop, i_ret_long, i_ret_short, amt} = {p, q, l, r, a};
		@(negedge i_mclk);
		{i_sp_push, i_sp_pop, i_ret_long, i_ret_short} = 4'h0;
		`CHK(o_stack_pointer, e)
	endtask
	// Word arithmetic flag update
	task automatic flg(input logic ad, input logic sb, input logic [19:0] s, input logic [19:0] d, input logic [15:0] e);
		@(negedge i_mclk);
		{i_flag_en, i_op_is_add, i_op_is_sub, i_op_src, i_op_dst, i_rd_size} = {1'h1, ad, sb, s, d, 2'h1};
		@(negedge i_mclk);
		i_flag_en = 1'h0;
		`CHK(o_status_word, e)
	endtask
	// Main sequence
	initial begin
		repeat (4) @(negedge i_mclk);
		i_srst = 1'h0;
		rd(4'h2, 2'h0, 2'h1, 20'h00000);
		`CHK(o_rd_is_const, 1'h0)
		`CHK(o_stack_pointer, 20'h00000)
		wr(4'h4, 2'h0, 1'h0, 20'h12345);
		rd(4'h4, 2'h0, 2'h0, 20'h00045);
		wr(4'h5, 2'h1, 1'h0, 20'h12345);
		rd(4'h5, 2'h0, 2'h1, 20'h02345);
		wr(4'h6, 2'h0, 1'h1, 20'h00080);
		rd(4'h6, 2'h0, 2'h2, 20'hFFF80);
		for (int i = 4; i < 16; i++) wr(4'(i), 2'h2, 1'h0, {4'(i), 16'hA5A5});
		for (int i = 4; i < 16; i++) rd(4'(i), 2'h0, 2'h2, {4'(i), 16'hA5A5});
		wr(4'h1, 2'h2, 1'h0, 20'h01235);
		`CHK(o_stack_pointer, 20'h01234)
		spo(1'h1, 1'h0, 1'h0, 1'h0, 20'h00002, 20'h01232);
		spo(1'h0, 1'h1, 1'h0, 1'h0, 20'h00002, 20'h01234);
		spo(1'h0, 1'h0, 1'h1, 1'h0, 20'h00000, 20'h01238);
		spo(1'h0, 1'h0, 1'h0, 1'h1, 20'h00000, 20'h0123A);
		wr(4'h2, 2'h1, 1'h0, 20'h000F8);
		`CHK({o_clock_gen_ctl_hi, o_clock_gen_ctl_lo, o_low_freq_xtal_off, o_core_halt, o_mirq_accept}, 5'h1F)
		i_xtal_in_use = 1'h1;
		#1 `CHK({o_low_freq_xtal_off, o_core_halt}, 2'h1)
		wr(4'h2, 2'h1, 1'h0, 20'h00000);
		`CHK({o_core_halt, o_mirq_accept}, 2'h0)
		rd(4'h3, 2'h0, 2'h1, 20'h00000);
		rd(4'h3, 2'h1, 2'h1, 20'h00001);
		rd(4'h3, 2'h3, 2'h0, 20'h000FF);
		rd(4'h3, 2'h3, 2'h1, 20'h0FFFF);
		rd(4'h3, 2'h3, 2'h2, 20'hFFFFF);
		rd(4'h2, 2'h1, 2'h1, 20'h00000);
		rd(4'h2, 2'h3, 2'h1, 20'h00008);
		`CHK(o_rd_is_const, 1'h1)
		wr(4'h3, 2'h2, 1'h0, 20'h12345);
		rd(4'h3, 2'h2, 2'h1, 20'h00002);
		flg(1'h1, 1'h0, 20'h00001, 20'h07FFF, 16'h0104);
		flg(1'h0, 1'h1, 20'h00001, 20'h08000, 16'h0101);
		flg(1'h1, 1'h0, 20'h00001, 20'h0FFFF, 16'h0003);
		// Clock enable low freezes the stack pointer
		@(negedge i_mclk);
		i_ce = 1'h0;
		spo(1'h1, 1'h0, 1'h0, 1'h0, 20'h00002, 20'h0123A);
		i_ce = 1'h1;
		finish_test;
	end
	// Hang guard
	initial begin
		#100000;
		err_count++;
		finish_test;
	end
endmodule
